// ### rtl/bcat_cfg_bank.sv
/*
  configuration tail register bank of the bridge function plus the mode-gated
  interrupt controller function header.
  assumes configuration accesses arrive one per cycle at most on core_clk, and that
  crc values, bus number and deferred-request events come from logic on core_clk.
*/
`timescale 1ns/100ps
module bcat_cfg_bank
  import bcat_pkg::*;
#(
  parameter logic [15:0] APIC_DEVICE_ID = 16'h0A5A,  // arbitrary value
  parameter logic [15:0] APIC_VENDOR_ID = 16'h05A5   // arbitrary value
) (
  // clock and resets
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          warm_reset,
  // mode straps from pins
  input  wire bcat_mode_t    mode_pins,
  // configuration access
  input  wire bcat_cfg_req_t cfg_req,
  output bcat_cfg_rsp_t      cfg_rsp,
  // bridge core status
  input  wire logic [7:0]    primary_bus_number,
  input  wire logic          split_request_deferred,
  // link crc capture
  input  wire logic          link0_crc_rx_load,
  input  wire logic [31:0]   link0_crc_rx_value,
  input  wire logic          link1_crc_exp_load,
  input  wire logic [31:0]   link1_crc_exp_value,
  input  wire logic          link1_crc_rx_load,
  input  wire logic [31:0]   link1_crc_rx_value,
  // controls to the bridge and interrupt logic
  output logic [15:0]        upstream_commit_limit,
  output logic [15:0]        downstream_commit_limit,
  output logic               apic_function_active,
  output logic               apic_mem_enable,
  output logic               apic_master_enable,
  output logic [51:0]        apic_bar_base
);

  // ==========================================================
  // mode decode
  bcat_mode_t mode_s;

  bcat_sync #(
    .WIDTH ($bits(bcat_mode_t))
  ) u_mode_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (mode_pins),
    .sync_out (mode_s)
  );

  logic diag_mode;
  logic generic_mode;
  logic f1_enable;

  always_comb begin
    diag_mode    = mode_s.single_bus | mode_s.dual_bus;
    generic_mode = mode_s.generic_single | mode_s.generic_dual;
    f1_enable    = generic_mode & mode_s.legacy_rev;
  end

  // ==========================================================
  // byte lane merge
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // register state
  logic [7:0]  bus_number;
  logic [4:0]  device_number;
  logic        defer_flag;
  logic [31:0] scratch;
  logic        cmd_mem_en;
  logic        cmd_master_en;
  logic [51:0] bar_base;
  logic        f1_active;
  logic [1:0]  apic_gate;
  bcat_cfg_rsp_t rsp;

  logic [7:0]  next_bus_number;
  logic [15:0] next_up_limit;
  logic [15:0] next_down_limit;
  logic        next_defer_flag;
  logic [31:0] next_scratch;
  logic        next_cmd_mem_en;
  logic        next_cmd_master_en;
  logic [51:0] next_bar_base;
  logic        next_f1_active;
  logic [1:0]  next_apic_gate;
  bcat_cfg_rsp_t next_rsp;

  logic        wr0;
  logic        wr1;
  logic [31:0] up_word;
  logic [31:0] down_word;
  logic [31:0] bar_lo_word;
  logic [31:0] bar_hi_word;
  logic [31:0] rd_value;

  // crc diagnostics sit on no reset so that neither reset disturbs them
  logic [31:0] link0_crc_rx;
  logic [31:0] link1_crc_exp;
  logic [31:0] link1_crc_rx;

  always_ff @(posedge core_clk) begin
    if (link0_crc_rx_load) begin
      link0_crc_rx <= link0_crc_rx_value;
    end
    if (link1_crc_exp_load) begin
      link1_crc_exp <= link1_crc_exp_value;
    end
    if (link1_crc_rx_load) begin
      link1_crc_rx <= link1_crc_rx_value;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    wr0 = cfg_req.valid & cfg_req.write & ~cfg_req.func;
    wr1 = cfg_req.valid & cfg_req.write & cfg_req.func & f1_enable;
    up_word     = merge_bytes({upstream_commit_limit, SPLIT_CAPACITY},
                              cfg_req.wdata, cfg_req.byte_en);
    down_word   = merge_bytes({downstream_commit_limit, SPLIT_CAPACITY},
                              cfg_req.wdata, cfg_req.byte_en);
    bar_lo_word = merge_bytes({bar_base[19:0], APIC_BAR_TYPE},
                              cfg_req.wdata, cfg_req.byte_en);
    bar_hi_word = merge_bytes(bar_base[51:20], cfg_req.wdata, cfg_req.byte_en);

    next_bus_number    = primary_bus_number;
    next_up_limit      = upstream_commit_limit;
    next_down_limit    = downstream_commit_limit;
    next_scratch       = scratch;
    next_cmd_mem_en    = cmd_mem_en;
    next_cmd_master_en = cmd_master_en;
    next_bar_base      = bar_base;
    next_f1_active     = f1_enable;
    next_defer_flag    = defer_flag;

    if (wr0 && !diag_mode && cfg_req.offset == OFS_UP_SPLIT) begin
      next_up_limit = up_word[31:16];
    end
    if (wr0 && !diag_mode && cfg_req.offset == OFS_DOWN_SPLIT) begin
      next_down_limit = down_word[31:16];
    end
    if (wr0 && diag_mode && cfg_req.offset == OFS_SCRATCH) begin
      next_scratch = merge_bytes(scratch, cfg_req.wdata, cfg_req.byte_en);
    end
    if (warm_reset) begin
      next_scratch = SCRATCH_RST;
    end
    // a new deferral in the clearing cycle keeps the flag set
    if (wr0 && !diag_mode && cfg_req.offset == OFS_CAP_STATUS && cfg_req.byte_en[2]
        && cfg_req.wdata[DEFER_FLAG_BIT]) begin
      next_defer_flag = 1'b0;
    end
    if (split_request_deferred) begin
      next_defer_flag = 1'b1;
    end
    if (wr1 && cfg_req.offset == OFS_APIC_CMD && cfg_req.byte_en[0]) begin
      next_cmd_mem_en    = cfg_req.wdata[1];
      next_cmd_master_en = cfg_req.wdata[2];
    end
    if (wr1 && cfg_req.offset == OFS_APIC_BAR_LO) begin
      next_bar_base[19:0] = bar_lo_word[31:12];
    end
    if (wr1 && cfg_req.offset == OFS_APIC_BAR_HI) begin
      next_bar_base[51:20] = bar_hi_word;
    end
    next_apic_gate = {next_cmd_master_en, next_cmd_mem_en} & {2{next_f1_active}};
  end

  // ==========================================================
  // read decode
  always_comb begin
    rd_value = '0;
    if (!cfg_req.func) begin
      case (cfg_req.offset)
        OFS_CAP_STATUS: begin
          if (diag_mode) begin
            rd_value = link0_crc_rx;
          end else begin
            rd_value = {10'h000, defer_flag, 3'h0, 2'h3,
                        (mode_s.legacy_rev ? NEXT_PTR_LEGACY : NEXT_PTR_NONE),
                        PCIX_CAP_ID};
          end
        end
        OFS_BRIDGE_STATUS: begin
          if (diag_mode) begin
            rd_value = link1_crc_exp;
          end else begin
            // upper half stays zero: the primary side is no parallel bus
            rd_value = {16'h0, bus_number, device_number, FUNCTION_NUM};
          end
        end
        OFS_UP_SPLIT: begin
          if (diag_mode) begin
            rd_value = link1_crc_rx;
          end else begin
            rd_value = {upstream_commit_limit, SPLIT_CAPACITY};
          end
        end
        OFS_DOWN_SPLIT: begin
          if (diag_mode) begin
            rd_value = scratch;
          end else begin
            rd_value = {downstream_commit_limit, SPLIT_CAPACITY};
          end
        end
        default: begin
          rd_value = '0;
        end
      endcase
    end else begin
      case (cfg_req.offset)
        OFS_APIC_IDENT:  rd_value = {APIC_DEVICE_ID, APIC_VENDOR_ID};
        OFS_APIC_CMD:    rd_value = {29'h0, cmd_master_en, cmd_mem_en, 1'b0};
        OFS_APIC_CLASS:  rd_value = {APIC_CLASS_CODE, APIC_REVISION};
        OFS_APIC_BAR_LO: rd_value = {bar_base[19:0], APIC_BAR_TYPE};
        OFS_APIC_BAR_HI: rd_value = bar_base[51:20];
        default:         rd_value = '0;
      endcase
    end

    next_rsp.valid     = cfg_req.valid;
    next_rsp.no_device = cfg_req.valid & cfg_req.func & ~f1_enable;
    if (next_rsp.no_device) begin
      next_rsp.rdata = NO_DEVICE_DATA;
    end else if (cfg_req.valid && !cfg_req.write) begin
      next_rsp.rdata = rd_value;
    end else begin
      next_rsp.rdata = '0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_number              <= BUS_NUM_RST;
      device_number           <= DEVICE_NUM_RST;
      upstream_commit_limit   <= COMMIT_LIMIT_RST;
      downstream_commit_limit <= COMMIT_LIMIT_RST;
      defer_flag              <= 1'b0;
      scratch                 <= SCRATCH_RST;
      cmd_mem_en              <= 1'b0;
      cmd_master_en           <= 1'b0;
      bar_base                <= '0;
      f1_active               <= 1'b0;
      apic_gate               <= 2'h0;
      rsp                     <= '0;
    end else begin
      bus_number              <= next_bus_number;
      upstream_commit_limit   <= next_up_limit;
      downstream_commit_limit <= next_down_limit;
      defer_flag              <= next_defer_flag;
      scratch                 <= next_scratch;
      cmd_mem_en              <= next_cmd_mem_en;
      cmd_master_en           <= next_cmd_master_en;
      bar_base                <= next_bar_base;
      f1_active               <= next_f1_active;
      apic_gate               <= next_apic_gate;
      rsp                     <= next_rsp;
    end
  end

  // routing goes through the controller set only while function 1 is live
  always_comb begin
    cfg_rsp              = rsp;
    apic_function_active = f1_active;
    apic_mem_enable      = apic_gate[0];
    apic_master_enable   = apic_gate[1];
    apic_bar_base        = bar_base;
  end

  // ==========================================================
  // checks
  bcat_cfg_req_t req_q;
  logic          diag_q;

  always_ff @(posedge core_clk) begin
    req_q  <= cfg_req;
    diag_q <= diag_mode;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_read0(logic [7:0] ofs, logic dm);
    rsp.valid && !req_q.write && !req_q.func && req_q.offset == ofs && diag_q == dm;
  endsequence

  a_status_upper_zero: assert property (s_read0(OFS_BRIDGE_STATUS, 1'b0)
    |-> rsp.rdata[31:16] == 16'h0000) else $error("bridge status upper half not zero");
  a_bus_number_read: assert property (s_read0(OFS_BRIDGE_STATUS, 1'b0)
    |-> rsp.rdata[15:8] == $past(bus_number)) else $error("bus number mismatch");
  a_device_number: assert property (s_read0(OFS_BRIDGE_STATUS, 1'b0)
    |-> rsp.rdata[7:3] == 5'h1F) else $error("device number wrong");
  a_function_zero: assert property (s_read0(OFS_BRIDGE_STATUS, 1'b0)
    |-> rsp.rdata[2:0] == 3'h0) else $error("function number not zero");
  a_up_capacity: assert property (s_read0(OFS_UP_SPLIT, 1'b0)
    |-> rsp.rdata == {$past(upstream_commit_limit), 16'h0005}) else $error("upstream word");
  a_down_capacity: assert property (s_read0(OFS_DOWN_SPLIT, 1'b0)
    |-> rsp.rdata == {$past(downstream_commit_limit), 16'h0005}) else $error("downstream word");
  a_limit_write: assert property (wr0 && !diag_mode && cfg_req.offset == OFS_UP_SPLIT
    && cfg_req.byte_en[3:2] == 2'b11 |=> upstream_commit_limit == $past(cfg_req.wdata[31:16]))
    else $error("upstream limit not written");
  a_down_write: assert property (wr0 && !diag_mode && cfg_req.offset == OFS_DOWN_SPLIT
    && cfg_req.byte_en[3:2] == 2'b11 |=> downstream_commit_limit == $past(cfg_req.wdata[31:16]))
    else $error("downstream limit not written");
  a_crc0_read: assert property (s_read0(OFS_LINK0_CRC_RX, 1'b1)
    |-> rsp.rdata == $past(link0_crc_rx)) else $error("link 0 crc read wrong");
  a_crc1_read: assert property (s_read0(OFS_LINK1_CRC_RX, 1'b1)
    |-> rsp.rdata == $past(link1_crc_rx)) else $error("link 1 crc read wrong");
  a_crc_hold: assert property (disable iff (1'b0) !$past(link1_crc_exp_load)
    |-> $stable(link1_crc_exp)) else $error("crc changed without load");
  a_scratch_warm: assert property (warm_reset |=> scratch == 32'h0)
    else $error("scratch survived warm reset");
  a_no_function1: assert property (rsp.valid && req_q.func && !$past(f1_enable)
    |-> rsp.no_device && rsp.rdata == 32'hFFFF_FFFF) else $error("function 1 answered");
  a_route_select: assert property (f1_enable |=> apic_function_active [*2] or !f1_enable)
    else $error("routing select lags mode");
  a_defer_sticky: assert property (split_request_deferred |=> defer_flag [*1])
    else $error("deferred flag lost");

endmodule

// ### rtl/bcat_pkg.sv
/*
  constants, field layouts and carrier types for the bridge configuration tail bank.
  assumes a dword-wide configuration access port on core_clk; byte offsets are dword aligned.
*/
// Contract
// - bridge status bits 31:16 read zero, reserved.
// - bridge status bits 15:8 read the primary bus number, reset zero.
// - bridge status bits 7:3 read own device number, initially 1Fh.
// - bridge status bits 2:0 read function number, fixed zero.
// - upstream commitment limit bits 31:16 writable, default 6h.
// - downstream commitment limit bits 31:16 writable, default 6h.
// - upstream control bits 15:0 read capacity 5h.
// - downstream control bits 15:0 read capacity 5h.
// - in single or dual bus mode F0h upward decode diagnostics and scratch.
// - in those modes F0h reads link 0 received crc.
// - in those modes F4h reads link 1 expected crc.
// - in those modes F8h reads link 1 received crc.
// - crc registers survive cold and warm reset.
// - in those modes FCh is read/write scratch, cleared by warm reset.
// - memory mapped interrupt controller register set per secondary port.
// - second function answers only in generic plus legacy revision mode.
// - with second function active, routing only via interrupt controller set.
// - sticky deferred-request flag set by hardware, cleared by writing one.
package bcat_pkg;

  // ==========================================================
  // function 0 offsets
  localparam logic [7:0] OFS_CAP_STATUS    = 8'hF0;
  localparam logic [7:0] OFS_BRIDGE_STATUS = 8'hF4;
  localparam logic [7:0] OFS_UP_SPLIT      = 8'hF8;
  localparam logic [7:0] OFS_DOWN_SPLIT    = 8'hFC;
  localparam logic [7:0] OFS_LINK0_CRC_RX  = 8'hF0;
  localparam logic [7:0] OFS_LINK1_CRC_EXP = 8'hF4;
  localparam logic [7:0] OFS_LINK1_CRC_RX  = 8'hF8;
  localparam logic [7:0] OFS_SCRATCH       = 8'hFC;

  // ==========================================================
  // function 1 offsets
  localparam logic [7:0] OFS_APIC_IDENT    = 8'h00;
  localparam logic [7:0] OFS_APIC_CMD      = 8'h04;
  localparam logic [7:0] OFS_APIC_CLASS    = 8'h08;
  localparam logic [7:0] OFS_APIC_BAR_LO   = 8'h10;
  localparam logic [7:0] OFS_APIC_BAR_HI   = 8'h14;

  // ==========================================================
  // fields and reset values
  localparam logic [15:0] COMMIT_LIMIT_RST = 16'h0006;
  localparam logic [15:0] SPLIT_CAPACITY   = 16'h0005;
  localparam logic [4:0]  DEVICE_NUM_RST   = 5'h1F;
  localparam logic [2:0]  FUNCTION_NUM     = 3'h0;
  localparam logic [7:0]  BUS_NUM_RST      = 8'h00;
  localparam logic [7:0]  PCIX_CAP_ID      = 8'h07;
  localparam logic [7:0]  NEXT_PTR_LEGACY  = 8'hC0;
  localparam logic [7:0]  NEXT_PTR_NONE    = 8'h00;
  localparam int          DEFER_FLAG_BIT   = 21;
  localparam logic [31:0] SCRATCH_RST      = 32'h0000_0000;
  localparam logic [31:0] NO_DEVICE_DATA   = 32'hFFFF_FFFF;
  localparam logic [23:0] APIC_CLASS_CODE  = 24'h080010;
  localparam logic [7:0]  APIC_REVISION    = 8'h01;
  localparam logic [11:0] APIC_BAR_TYPE    = 12'h004;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        single_bus;
    logic        dual_bus;
    logic        generic_single;
    logic        generic_dual;
    logic        legacy_rev;
  } bcat_mode_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        func;
    logic [7:0]  offset;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } bcat_cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic        no_device;
    logic [31:0] rdata;
  } bcat_cfg_rsp_t;

endpackage

// ### rtl/bcat_sync.sv
/*
  two flip-flop synchroniser for level inputs arriving from pins.
  assumes the inputs are quasi-static levels; no pulse is guaranteed to pass.
*/
`timescale 1ns/100ps
module bcat_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_meta     = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule

// ### testbench/test_bridge_cfg_tail_and_apic_header.sv
/*
  self-checking bench for the bridge configuration tail bank and its interrupt controller header.
  assumes one answer per request one edge later and straps settling within four edges.
*/
`timescale 1ns/100ps
module test_bridge_cfg_tail_and_apic_header;
  import bcat_pkg::*;
  // ==========================================================
  // signals
  localparam logic [15:0] DEV_ID = 16'h3C3C;  // arbitrary value
  localparam logic [15:0] VEN_ID = 16'h0F0F;  // arbitrary value
  logic          core_clk;
  logic          reset;
  logic          warm_reset;
  bcat_mode_t    mode_pins;
  bcat_cfg_req_t cfg_req;
  bcat_cfg_rsp_t cfg_rsp;
  logic [7:0]    bus_num;
  logic          deferred;
  logic [2:0]    crc_load;
  logic [31:0]   crc_val [3];
  logic [31:0]   crc_exp [3];
  logic [15:0]   up_lim;
  logic [15:0]   down_lim;
  logic          apic_act;
  logic          mem_en;
  logic          mst_en;
  logic [51:0]   bar;
  logic [31:0]   rd_data;
  logic          rd_nodev;
  logic [31:0]   wd;
  logic [15:0]   lim;
  int            n_errors;
  int            comparisons;

  bcat_cfg_bank #(.APIC_DEVICE_ID(DEV_ID), .APIC_VENDOR_ID(VEN_ID)) i_dut (
    .core_clk(core_clk), .reset(reset), .warm_reset(warm_reset), .mode_pins(mode_pins),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .primary_bus_number(bus_num),
    .split_request_deferred(deferred),
    .link0_crc_rx_load(crc_load[0]), .link0_crc_rx_value(crc_val[0]),
    .link1_crc_exp_load(crc_load[1]), .link1_crc_exp_value(crc_val[1]),
    .link1_crc_rx_load(crc_load[2]), .link1_crc_rx_value(crc_val[2]),
    .upstream_commit_limit(up_lim), .downstream_commit_limit(down_lim),
    .apic_function_active(apic_act), .apic_mem_enable(mem_en),
    .apic_master_enable(mst_en), .apic_bar_base(bar));

  // ==========================================================
  // expectations
  function automatic logic [31:0] exp_cap(input logic flag, input logic legacy);
    return {10'h000, flag, 5'h03, (legacy ? 8'hC0 : 8'h00), 8'h07};
  endfunction
  function automatic logic [31:0] exp_status(input logic [7:0] bus);
    return {16'h0000, bus, 5'h1F, 3'h0};
  endfunction

  // ==========================================================
  // checking and ending
  task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected word at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic check_bit(input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected bit at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // drivers; every change lands 1 ns after a rising edge
  task automatic access(input logic wr, input logic fn, input logic [7:0] ofs,
                        input logic [3:0] be, input logic [31:0] data);
    @(posedge core_clk);
    #1;
    cfg_req = {1'b1, wr, fn, ofs, be, data};
    @(posedge core_clk);
    #1;
    cfg_req.valid = 1'b0;
    rd_data  = cfg_rsp.rdata;
    rd_nodev = cfg_rsp.no_device;
    check_bit(1'b1, cfg_rsp.valid);
  endtask
  // straps pass two sync flops plus the decode flop, so four edges cover it
  task automatic set_mode(input logic [4:0] m);
    @(posedge core_clk);
    #1;
    mode_pins = m;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk);
    #1;
    if (k < 3) begin
      crc_exp[k]  = $urandom;
      crc_val[k]  = crc_exp[k];
      crc_load[k] = 1'b1;
    end else if (k == 3) deferred = 1'b1;
    else if (k == 4) warm_reset = 1'b1;
    else reset = 1'b1;
    @(posedge core_clk);
    #1;
    crc_load   = 3'h0;
    deferred   = 1'b0;
    warm_reset = 1'b0;
    reset      = 1'b0;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    wrap_up();
  end

  // ==========================================================
  // tests
  initial begin
    reset = 1'b1;
    warm_reset = 1'b0;
    mode_pins = '0;
    cfg_req = '0;
    bus_num = 8'h00;
    deferred = 1'b0;
    // power-up loads give the crc registers a known start
    crc_load = 3'h7;
    for (int i = 0; i < 3; i++) crc_val[i] = 32'h0;
    n_errors = 0;
    comparisons = 0;
    void'($urandom(39));
    repeat (16) @(posedge core_clk);
    #1;
    reset = 1'b0;
    crc_load = 3'h0;
    // reset values with generic single bus, no legacy revision
    set_mode(5'h04);
    access(0, 0, 8'hF4, 4'hF, 32'h0);
    check_word(exp_status(8'h00), rd_data);
    bus_num = 8'($urandom);
    access(1, 0, 8'hF4, 4'hF, 32'hFFFF_FFFF);
    access(0, 0, 8'hF4, 4'hF, 32'h0);
    check_word(exp_status(bus_num), rd_data);
    access(0, 0, 8'hF8, 4'hF, 32'h0);
    check_word(32'h0006_0005, rd_data);
    access(0, 0, 8'hFC, 4'hF, 32'h0);
    check_word(32'h0006_0005, rd_data);
    access(0, 0, 8'hF0, 4'hF, 32'h0);
    check_word(exp_cap(1'b0, 1'b0), rd_data);
    access(0, 1, 8'h00, 4'hF, 32'h0);
    check_word(32'hFFFF_FFFF, rd_data);
    check_bit(1'b1, rd_nodev);
    $display("test reset values done");
    // limits: full lanes, then partial lanes; capacity stays read-only
    for (int i = 0; i < 2; i++) begin
      lim = 16'($urandom);
      wd  = $urandom;
      access(1, 0, (i == 0) ? 8'hF8 : 8'hFC, 4'hC, {lim, wd[15:0]});
      access(1, 0, (i == 0) ? 8'hF8 : 8'hFC, 4'h3, 32'hFFFF_FFFF);
      access(1, 0, (i == 0) ? 8'hF8 : 8'hFC, 4'h4, {8'h00, ~lim[7:0], 16'hFFFF});
      access(0, 0, (i == 0) ? 8'hF8 : 8'hFC, 4'hF, 32'h0);
      lim = {lim[15:8], ~lim[7:0]};
      check_word({lim, 16'h0005}, rd_data);
      check_word({16'h0, lim}, {16'h0, (i == 0) ? up_lim : down_lim});
    end
    // software puts the limits back to their defaults
    access(1, 0, 8'hF8, 4'hC, 32'h0006_0000);
    access(1, 0, 8'hFC, 4'hC, 32'h0006_0000);
    check_word(32'h0006_0006, {up_lim, down_lim});
    $display("test split limits done");
    // deferred flag is sticky; a clear needs lane 2 and bit 21
    pulse(3);
    access(1, 0, 8'hF0, 4'h3, 32'hFFFF_FFFF);
    access(0, 0, 8'hF0, 4'hF, 32'h0);
    check_word(exp_cap(1'b1, 1'b0), rd_data);
    access(1, 0, 8'hF0, 4'h4, 32'h0020_0000);
    access(0, 0, 8'hF0, 4'hF, 32'h0);
    check_word(exp_cap(1'b0, 1'b0), rd_data);
    // a deferral in the clearing cycle must win
    fork
      pulse(3);
      access(1, 0, 8'hF0, 4'h4, 32'h0020_0000);
    join
    access(0, 0, 8'hF0, 4'hF, 32'h0);
    check_word(exp_cap(1'b1, 1'b0), rd_data);
    access(1, 0, 8'hF0, 4'h4, 32'h0020_0000);
    access(0, 0, 8'hF0, 4'hF, 32'h0);
    check_word(exp_cap(1'b0, 1'b0), rd_data);
    $display("test deferred flag done");
    // diagnostic mode: crc survives both resets, scratch only cold-to-zero and warm-to-zero
    set_mode(5'h10);
    for (int k = 0; k < 3; k++) pulse(k);
    wd = $urandom;
    access(1, 0, 8'hFC, 4'hF, wd);
    access(0, 0, 8'hFC, 4'hF, 32'h0);
    check_word(wd, rd_data);
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 3; k++) begin
        access(1, 0, 8'hF0 + 8'(4 * k), 4'hF, ~crc_exp[k]);
        access(0, 0, 8'hF0 + 8'(4 * k), 4'hF, 32'h0);
        check_word(crc_exp[k], rd_data);
      end
      if (r == 0) pulse(4);
      if (r == 1) pulse(5);
      if (r == 1) set_mode(5'h08);
      if (r < 2) access(0, 0, 8'hFC, 4'hF, 32'h0);
      if (r < 2) check_word(32'h0, rd_data);
    end
    check_word({16'h0006, 16'h0006}, {up_lim, down_lim});
    $display("test diagnostics done");
    // second function: refused while off, live in generic plus legacy revision mode
    access(1, 1, 8'h04, 4'h1, 32'h0000_0006);
    set_mode(5'h05);
    check_bit(1'b1, apic_act);
    access(0, 1, 8'h00, 4'hF, 32'h0);
    check_word({DEV_ID, VEN_ID}, rd_data);
    access(0, 1, 8'h04, 4'hF, 32'h0);
    check_word(32'h0, rd_data);
    access(1, 1, 8'h04, 4'h1, 32'h0000_0006);
    check_word(32'h3, {30'h0, mst_en, mem_en});
    access(0, 1, 8'h04, 4'hF, 32'h0);
    check_word(32'h0000_0006, rd_data);
    access(0, 1, 8'h08, 4'hF, 32'h0);
    check_word({APIC_CLASS_CODE, APIC_REVISION}, rd_data);
    wd = $urandom;
    access(1, 1, 8'h10, 4'hF, wd);
    access(0, 1, 8'h10, 4'hF, 32'h0);
    check_word({wd[31:12], 12'h004}, rd_data);
    check_word({12'h0, wd[31:12]}, {12'h0, bar[19:0]});
    access(1, 1, 8'h14, 4'hF, ~wd);
    access(0, 1, 8'h14, 4'hF, 32'h0);
    check_word(~wd, rd_data);
    check_word(~wd, bar[51:20]);
    access(0, 0, 8'hF0, 4'hF, 32'h0);
    check_word(exp_cap(1'b0, 1'b1), rd_data);
    set_mode(5'h03);
    check_bit(1'b1, apic_act);
    set_mode(5'h02);
    check_bit(1'b0, apic_act);
    check_bit(1'b0, mem_en);
    access(0, 1, 8'h00, 4'hF, 32'h0);
    check_bit(1'b1, rd_nodev);
    $display("test second function done");
    wrap_up();
  end
endmodule
